// ### src/cmy_calendar_month_year.v
// Calendar month and year counters with buffered software access
//
// How it works
// RULE1: Month counts 1..12, advances on day overflow
// RULE2: Writes buffered, reach counter within two ticks
// RULE3: Pending month write beats a day overflow
// RULE4: Pending year write beats a month overflow
// RULE5: Month is BCD 01..12, bits 7..5 zero
// RULE6: Year is BCD 00..99, two digits
// RULE7: Year counts 0..99, advances on month overflow
// RULE8: Years divisible by four are leap years
// RULE9: Reset loads month with one
// RULE10: Reset loads year with zero
// RULE11: Software uses whole-byte accesses only
// RULE12: Software follows safe sequence while running
// RULE13: Month wraps 12 to 1, year 99 to 0
//
// The day stage and the timekeeping clock live outside. The timekeeping
// clock arrives as a one-cycle tick on core_clk; the day overflow is a
// one-cycle pulse on the same clock. Both stages count only while the
// run enable is high, but writes still transfer so software can preset
// the calendar before starting it.
`timescale 1ns/100ps
`default_nettype none

`include "cmy_consts.vh"

module cmy_calendar_month_year #(
  parameter ADDR_W = `CMY_ADDR_W
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              reset,
  // Timekeeping inputs
  input  wire              timekeeping_clock,
  input  wire              calendar_run_enable,
  input  wire              day_overflow,
  // Register access port, one byte per access
  input  wire [ADDR_W-1:0] sfr_addr,
  input  wire              sfr_wr,
  input  wire              sfr_rd,
  input  wire [7:0]        sfr_wdata,
  output reg  [7:0]        sfr_rdata,
  output reg               sfr_hit,
  // Calendar state
  output wire [7:0]        month_value,
  output wire [7:0]        year_value,
  output reg               leap_year,
  output wire              year_overflow,
  output wire              write_pending,
  output reg               bad_write
);

  // Address decode strobes
  wire       month_sel;
  wire       year_sel;
  wire       month_wr;
  wire       year_wr;

  // Stage outputs
  wire [7:0] month_q;
  wire [7:0] year_q;
  wire       month_carry;
  wire       year_carry;
  wire       month_pend;
  wire       year_pend;

  // Read path and checks
  reg  [7:0] rdata_d;
  reg        hit_d;
  reg        leap_d;
  reg        wdata_ok;
  reg  [3:0] wdata_tens;
  reg  [3:0] wdata_units;

  // Decode, only exact byte addresses respond
  assign month_sel = (sfr_addr == `CMY_MONTH_ADDR);
  assign year_sel  = (sfr_addr == `CMY_YEAR_ADDR);
  assign month_wr  = sfr_wr && month_sel;
  assign year_wr   = sfr_wr && year_sel;

  // Month stage; counts on the day overflow pulse
  cmy_bcd_stage #(
    .MIN_VAL   (`CMY_MONTH_MIN),
    .MAX_VAL   (`CMY_MONTH_MAX),
    .RESET_VAL (`CMY_MONTH_RESET),
    .VAL_MASK  (`CMY_MONTH_MASK)
  ) u_month (
    .core_clk  (core_clk),
    .reset     (reset),
    .tick      (timekeeping_clock),
    .run_en    (calendar_run_enable),
    .carry_in  (day_overflow),
    .wr_stb    (month_wr),
    .wr_data   (sfr_wdata),
    .value_q   (month_q),
    .carry_q   (month_carry),
    .pending_q (month_pend)
  ); // RULE1 RULE3 RULE5 RULE9 RULE13

  // Year stage; counts on the month wrap pulse
  cmy_bcd_stage #(
    .MIN_VAL   (`CMY_YEAR_MIN),
    .MAX_VAL   (`CMY_YEAR_MAX),
    .RESET_VAL (`CMY_YEAR_RESET),
    .VAL_MASK  (`CMY_YEAR_MASK)
  ) u_year (
    .core_clk  (core_clk),
    .reset     (reset),
    .tick      (timekeeping_clock),
    .run_en    (calendar_run_enable),
    .carry_in  (month_carry),
    .wr_stb    (year_wr),
    .wr_data   (sfr_wdata),
    .value_q   (year_q),
    .carry_q   (year_carry),
    .pending_q (year_pend)
  ); // RULE4 RULE6 RULE7 RULE10 RULE13

  assign month_value   = month_q;
  assign year_value    = year_q;
  assign year_overflow = year_carry;
  // High from a write until its value sits in the counter
  assign write_pending = month_pend || year_pend; // RULE2

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    hit_d   = 1'b0;
    if (month_sel) begin
      rdata_d = month_q & `CMY_MONTH_MASK; // RULE5
      hit_d   = 1'b1;
    end else if (year_sel) begin
      rdata_d = year_q; // RULE6
      hit_d   = 1'b1;
    end
  end

  // Leap year: BCD multiple of four, even tens with 0/4/8 or odd
  // tens with 2/6
  always @* begin
    if (year_q[`CMY_TENS_LSB])
      leap_d = (year_q[3:0] == 4'h2) || (year_q[3:0] == 4'h6);
    else
      leap_d = (year_q[3:0] == 4'h0) || (year_q[3:0] == 4'h4) ||
               (year_q[3:0] == 4'h8);
  end // RULE8

  // Write value check; the counter trusts software, this only flags it
  always @* begin
    wdata_tens  = sfr_wdata[7:`CMY_TENS_LSB];
    wdata_units = sfr_wdata[`CMY_UNITS_MSB:0];
    wdata_ok    = 1'b1;
    if (month_wr) begin
      wdata_ok = (sfr_wdata >= `CMY_MONTH_MIN) &&
                 (sfr_wdata <= `CMY_MONTH_MAX) &&
                 (wdata_units <= `CMY_UNITS_NINE);
    end else if (year_wr) begin
      wdata_ok = (wdata_tens <= `CMY_UNITS_NINE) &&
                 (wdata_units <= `CMY_UNITS_NINE);
    end
  end // RULE5 RULE6

  // Registered read data, leap flag and bad-write flag
  always @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
      leap_year <= 1'b1;
      bad_write <= 1'b0;
    end else begin
      sfr_hit   <= sfr_rd && hit_d;
      leap_year <= leap_d;
      // Holding the last data keeps a slow reader stable
      if (sfr_rd)
        sfr_rdata <= rdata_d;
      // Sticky until the next accepted write of a legal value
      if (month_wr || year_wr)
        bad_write <= !wdata_ok;
    end
  end

endmodule

`default_nettype wire

// ### src/cmy_consts.vh
// Constants for the calendar month and year counter stages
`ifndef CMY_CONSTS_VH
`define CMY_CONSTS_VH

// Register addresses on the special function register space
`define CMY_ADDR_W          20
`define CMY_MONTH_ADDR      20'hFFF97
`define CMY_YEAR_ADDR       20'hFFF98

// Reset values
`define CMY_MONTH_RESET     8'h01
`define CMY_YEAR_RESET      8'h00

// Counting ranges in BCD
`define CMY_MONTH_MIN       8'h01
`define CMY_MONTH_MAX       8'h12
`define CMY_YEAR_MIN        8'h00
`define CMY_YEAR_MAX        8'h99

// Field layout: month bits 7..5 always zero
`define CMY_MONTH_MASK      8'h1F
`define CMY_YEAR_MASK       8'hFF
`define CMY_UNITS_MSB       3
`define CMY_TENS_LSB        4
`define CMY_UNITS_NINE      4'h9

// Holding buffer reaches the counter within this many timekeeping clocks
`define CMY_XFER_TICKS      2

`endif

// ### src/cmy_bcd_stage.v
// One buffered BCD counter stage of the calendar (month or year)
`timescale 1ns/100ps
`default_nettype none

`include "cmy_consts.vh"

module cmy_bcd_stage #(
  parameter [7:0] MIN_VAL   = `CMY_YEAR_MIN,
  parameter [7:0] MAX_VAL   = `CMY_YEAR_MAX,
  parameter [7:0] RESET_VAL = `CMY_YEAR_RESET,
  parameter [7:0] VAL_MASK  = `CMY_YEAR_MASK
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset,
  // Timekeeping
  input  wire       tick,
  input  wire       run_en,
  input  wire       carry_in,
  // Software write
  input  wire       wr_stb,
  input  wire [7:0] wr_data,
  // Results
  output reg  [7:0] value_q,
  output reg        carry_q,
  output reg        pending_q
);

  reg [7:0] buffer_q;
  reg [7:0] value_d;
  reg       carry_d;

  // Next count: BCD increment with wrap from MAX back to MIN
  always @* begin
    value_d = value_q;
    carry_d = 1'b0;
    if (value_q == MAX_VAL) begin
      value_d = MIN_VAL;
      carry_d = 1'b1;
    end else if (value_q[`CMY_UNITS_MSB:0] == `CMY_UNITS_NINE) begin
      value_d = {value_q[7:`CMY_TENS_LSB] + 4'h1, 4'h0};
    end else begin
      value_d = {value_q[7:`CMY_TENS_LSB],
                 value_q[`CMY_UNITS_MSB:0] + 4'h1};
    end
  end

  // Holding buffer, transfer on the next timekeeping clock
  always @(posedge core_clk) begin
    if (reset) begin
      buffer_q  <= RESET_VAL;
      pending_q <= 1'b0;
      value_q   <= RESET_VAL;
      carry_q   <= 1'b0;
    end else begin
      carry_q <= 1'b0;
      if (wr_stb) begin
        // A fresh write restarts the wait, so the newest value wins
        buffer_q  <= wr_data & VAL_MASK;
        pending_q <= 1'b1;
      end else if (tick && pending_q) begin
        pending_q <= 1'b0;
      end
      if (tick && pending_q && !wr_stb) begin
        // Carry in this cycle is dropped in favour of the written value
        value_q <= buffer_q;
      end else if (carry_in && run_en && !pending_q) begin
        value_q <= value_d;
        carry_q <= carry_d;
      end
    end
  end

endmodule

`default_nettype wire

// ### verification/cmy_checker.sv
// Assertion checker for the calendar month and year block
`timescale 1ns/100ps
`default_nettype none
module cmy_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Inputs of the block
  input wire logic        timekeeping_clock,
  input wire logic        calendar_run_enable,
  input wire logic        day_overflow,
  input wire logic [19:0] sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  // Outputs of the block
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic [7:0]  month_value,
  input wire logic [7:0]  year_value,
  input wire logic        leap_year,
  input wire logic        year_overflow,
  input wire logic        write_pending,
  input wire logic        bad_write
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // BCD leap test: even tens need units 0/4/8, odd tens need 2/6
  wire logic lp = year_value[4] ? (year_value[1:0] == 2'b10)
                                : (year_value[1:0] == 2'b00);
  // A counting day overflow; a pending month write would swallow it, a pending year write the year carry
  wire logic dc = day_overflow && calendar_run_enable && !write_pending;
  wire logic mw = sfr_wr && sfr_addr == 20'hFFF97;
  AST_RD_MONTH:
    assert property (sfr_rd && sfr_addr == 20'hFFF97 |=> sfr_hit &&
      sfr_rdata == $past(month_value)) else $error("bad month read");
  AST_MONTH_BITS:
    assert property (month_value[7:5] == 3'h0) else $error("month msb");
  AST_WR_PEND:
    assert property (mw |=> write_pending) else $error("no pending");
  AST_XFER:
    assert property (write_pending && timekeeping_clock && !sfr_wr
      |=> !write_pending) else $error("late transfer");
  AST_M_INC:
    assert property (dc && month_value == 8'h09 |=> month_value == 8'h10)
      else $error("month step");
  AST_M_WRAP:
    assert property (dc && month_value == 8'h12 |=> month_value == 8'h01)
      else $error("month wrap");
  AST_Y_WRAP:
    assert property (dc && month_value == 8'h12 && year_value == 8'h99
      |=> ##1 year_value == 8'h00 && year_overflow) else $error("year");
  AST_LEAP:
    assert property (leap_year == $past(lp)) else $error("leap flag");
  AST_HOLD:
    assert property ((!calendar_run_enable && !write_pending)[*3] |->
      $stable(month_value) && $stable(year_value)) else $error("ran");
  cover property (dc && month_value == 8'h12);
  cover property (mw && day_overflow);
  cover property (year_overflow);
endmodule
bind cmy_calendar_month_year cmy_checker i_cmy_checker (.*);
`default_nettype wire

// ### verification/cmy_calendar_month_year_tb_top.sv
// Self-checking bench for the calendar month and year block
`timescale 1ns/100ps
`default_nettype none
`include "cmy_consts.vh"
module cmy_calendar_month_year_tb_top;
  localparam logic [19:0] MA = `CMY_MONTH_ADDR;
  localparam logic [19:0] YA = `CMY_YEAR_ADDR;
  // Design inputs
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        timekeeping_clock = 1'b0;
  logic        calendar_run_enable = 1'b1;
  logic        day_overflow = 1'b0;
  logic [19:0] sfr_addr = 20'h00000;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  // Design outputs
  logic [7:0]  sfr_rdata, month_value, year_value;
  logic        sfr_hit, leap_year, year_overflow, write_pending, bad_write;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  cmy_calendar_month_year i_cmy_calendar_month_year (.*);
  initial forever #25 core_clk = ~core_clk;
  // Cut a hang short; the whole run needs well under 1000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize;
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One byte-wide strobe cycle; read data settles just after the taking
  // edge. The bench keeps whole-byte transfers only.
  // It also steps the calendar itself, so no safe sequence is needed.
  task automatic acc(input logic w, input logic [19:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask
  // Tick or day pulse; waits an extra edge so a year carry lands
  task automatic pls(input logic day);
    @(posedge core_clk);
    day_overflow <= day;
    timekeeping_clock <= !day;
    @(posedge core_clk);
    day_overflow <= 1'b0;
    timekeeping_clock <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic set(input logic [7:0] m, input logic [7:0] y);
    acc(1'b1, MA, m);
    acc(1'b1, YA, y);
    pls(1'b0);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    acc(1'b0, MA, 8'h00);
    chk(sfr_rdata, 8'h01);
    chk({7'h00, sfr_hit}, 8'h01);
    acc(1'b0, YA, 8'h00);
    chk(sfr_rdata, 8'h00);
    acc(1'b0, 20'h00000, 8'h00);
    chk({7'h00, sfr_hit}, 8'h00);
    acc(1'b1, MA, 8'hE9);
    chk({7'h00, bad_write}, 8'h01);
    pls(1'b0);
    chk(month_value, 8'h09);
    pls(1'b1);
    chk(month_value, 8'h10);
    set(8'h12, 8'h99);
    pls(1'b1);
    chk(month_value, 8'h01);
    chk(year_value, 8'h00);
    chk({7'h00, year_overflow}, 8'h01);
    chk({7'h00, bad_write}, 8'h00);
    set(8'h12, 8'h23);
    pls(1'b1);
    acc(1'b0, YA, 8'h00);
    chk(sfr_rdata, 8'h24);
    chk({7'h00, leap_year}, 8'h01);
    set(8'h12, 8'h39);
    acc(1'b1, MA, 8'h05);
    chk({7'h00, write_pending}, 8'h01);
    pls(1'b1);
    chk(month_value, 8'h12);
    chk(year_value, 8'h39);
    chk({7'h00, leap_year}, 8'h00);
    pls(1'b0);
    chk(month_value, 8'h05);
    set(8'h12, 8'h49);
    acc(1'b1, YA, 8'h70);
    pls(1'b1);
    chk(year_value, 8'h49);
    pls(1'b0);
    chk(year_value, 8'h70);
    // Stopped calendar ignores the day stage
    @(posedge core_clk);
    calendar_run_enable <= 1'b0;
    pls(1'b1);
    chk(month_value, 8'h01);
    summarize();
  end
endmodule
`default_nettype wire
